//--- hw/angle_sensor_params.svh
// Purpose: constants for the angle sensor configuration words
// Assumes: included by the package and the design file
// Notes:   offsets are word indices on the plain register port
`ifndef ANGLE_SENSOR_PARAMS_SVH
`define ANGLE_SENSOR_PARAMS_SVH

// ==========================================================
// Register map
`define ADDR_W              8
`define WORD_W              24
`define OFS_FAULT_MASK      8'h1A
`define OFS_OUTPUT_CFG      8'h1B
`define OFS_POSITION_CFG    8'h1C
`define OFS_IDLE_POWER_CFG  8'h1D
`define OFS_BLOCK_STATUS    8'h40
`define RST_WORD            24'h000000

// ==========================================================
// Fault mask word fields
`define BIT_CAUTION_SUPPRESS 11
`define BIT_SPI_CHECK_FAULT  22
`define FAULT_BITS          24'hDFF7FF
`define CAUTION_BITS        24'h118000

// ==========================================================
// Output interface word fields
`define BIT_INBOUND_CHECK   0
`define BIT_SKIP_EXTRA_EDGE 1
`define BIT_TURNS_USE_HYST  2
`define BIT_IGNORE_SUPPLY   3
`define BIT_OFFSET_AFTER    7
`define BIT_LIN_SPAN        10
`define BIT_LIN_ENABLE      11
`define BIT_PWM_STYLE       12
`define BIT_PWM_FAULT_OUT   13
`define BIT_PWM_HYST_EN     14
`define PWM_RATE_HI         19
`define PWM_RATE_LO         16
`define BIT_PWM_OUT_EN      23

// ==========================================================
// Position processing word fields
`define ZERO_OFS_HI         11
`define HYST_HI             17
`define HYST_LO             12
`define BIT_TURN_SENSE      18
`define BIT_HALF_TURN       19
`define AVG_EXP_HI          23
`define AVG_EXP_LO          20
`define AVG_EXP_MAX         4'hC
`define HALF_TURN           12'h800
`define LIN_SHIFT_NARROW    3
`define LIN_SHIFT_WIDE      2

// ==========================================================
// Idle power word fields and timing
`define WAKE_HI             10
`define IDLE_PER_HI         17
`define IDLE_PER_LO         12
`define IDLE_STEP_NS        64'd8192000
`define CLK_MHZ             64'd250

`endif

//--- hw/angle_sensor_pkg.sv
// Purpose: shared types of the angle sensor configuration block
// Assumes: constants come from angle_sensor_params.svh
// Notes:   none
`include "angle_sensor_params.svh"

package angle_sensor_pkg;
    typedef logic [`WORD_W-1:0] word_t;
    typedef logic [11:0]        angle_t;
    typedef enum logic [1:0] {
        PWM_NORMAL,
        PWM_RELEASED,
        PWM_HALF_RATE
    } pwm_mode_t;
endpackage

//--- hw/angle_sensor_config_words.sv
// Purpose: configuration words of a magnetic angle sensor and the logic they steer
// Assumes: fault, angle and PWM inputs are synchronous to ref_clk_i
// Notes:   supply link input is asynchronous and passes a three-stage synchroniser
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "angle_sensor_params.svh"

module angle_sensor_config_words
    import angle_sensor_pkg::*;
#(
    parameter int IDLE_STEP_CYCLES = int'(`IDLE_STEP_NS * `CLK_MHZ / 64'd1000),
    parameter int PWM_ERR_N        = 11
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_i,
    input  wire logic [`ADDR_W-1:0]    reg_addr_i,
    input  wire logic [`WORD_W-1:0]    reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic      [`WORD_W-1:0]    reg_rdata_o,
    input  wire logic [`WORD_W-1:0]    error_i,
    input  wire logic                  spi_crc_bad_i,
    input  wire logic                  spi_edge17_i,
    input  wire logic                  supply_link_i,
    input  wire logic                  angle_valid_i,
    input  wire logic [11:0]           angle_i,
    input  wire logic [11:0]           lin_corr_i,
    input  wire logic                  low_power_i,
    input  wire logic [PWM_ERR_N-1:0]  pwm_err_i,
    input  wire logic                  pwm_wave_i,
    output logic                       fault_flag_o,
    output logic                       caution_bit_o,
    output logic                       spi_edge_count_o,
    output logic                       supply_link_o,
    output logic [11:0]                angle_out_o,
    output logic                       angle_valid_o,
    output logic [11:0]                turns_angle_out_o,
    output logic [11:0]                pwm_angle_o,
    output logic                       pwm_pin_o,
    output logic                       pwm_oe_o,
    output logic                       pwm_half_rate_o,
    output logic [3:0]                 pwm_err_code_o,
    output logic [3:0]                 pwm_rate_code_o,
    output logic                       force_normal_o,
    output logic                       idle_allowed_o
);

    initial begin
        if (IDLE_STEP_CYCLES < 2 || PWM_ERR_N < 1 || PWM_ERR_N > 15) begin
            $error("angle_sensor_config_words: unsupported parameter value");
        end
    end

    // ==========================================================
    // Register file
    word_t fault_mask_word;
    word_t output_interface_config;
    word_t position_processing_config;
    word_t idle_power_config;
    word_t block_status;

    wire hit_mask = reg_addr_i == `OFS_FAULT_MASK;
    wire hit_out  = reg_addr_i == `OFS_OUTPUT_CFG;
    wire hit_pos  = reg_addr_i == `OFS_POSITION_CFG;
    wire hit_idle = reg_addr_i == `OFS_IDLE_POWER_CFG;
    wire hit_stat = reg_addr_i == `OFS_BLOCK_STATUS;
    // Unmapped addresses read as zero
    wire word_t rd_mux = hit_mask ? fault_mask_word :
                         hit_out  ? output_interface_config :
                         hit_pos  ? position_processing_config :
                         hit_idle ? idle_power_config :
                         hit_stat ? block_status : `RST_WORD;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            fault_mask_word            <= `RST_WORD;
            output_interface_config    <= `RST_WORD;
            position_processing_config <= `RST_WORD;
            idle_power_config          <= `RST_WORD;
        end else if (reg_wr_i) begin
            if (hit_mask) fault_mask_word <= reg_wdata_i;
            if (hit_out)  output_interface_config <= reg_wdata_i;
            if (hit_pos)  position_processing_config <= reg_wdata_i;
            if (hit_idle) idle_power_config <= reg_wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= `RST_WORD;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_mux : `RST_WORD;
        end
    end

    // ==========================================================
    // Field decode
    wire inbound_check_enable = output_interface_config[`BIT_INBOUND_CHECK];
    wire skip_extra_edge      = output_interface_config[`BIT_SKIP_EXTRA_EDGE];
    wire turns_use_hyst       = output_interface_config[`BIT_TURNS_USE_HYST];
    wire ignore_supply_link   = output_interface_config[`BIT_IGNORE_SUPPLY];
    wire offset_after_lin     = output_interface_config[`BIT_OFFSET_AFTER];
    wire lin_span             = output_interface_config[`BIT_LIN_SPAN];
    wire lin_enable           = output_interface_config[`BIT_LIN_ENABLE];
    wire pwm_fault_style      = output_interface_config[`BIT_PWM_STYLE];
    wire pwm_fault_out_en     = output_interface_config[`BIT_PWM_FAULT_OUT];
    wire pwm_hyst_en          = output_interface_config[`BIT_PWM_HYST_EN];
    wire pwm_out_en           = output_interface_config[`BIT_PWM_OUT_EN];
    wire [3:0] pwm_rate_code  = output_interface_config[`PWM_RATE_HI:`PWM_RATE_LO];
    wire angle_t zero_offset  = position_processing_config[`ZERO_OFS_HI:0];
    wire [5:0] hyst_thr       = position_processing_config[`HYST_HI:`HYST_LO];
    wire turn_sense           = position_processing_config[`BIT_TURN_SENSE];
    wire half_turn_flip       = position_processing_config[`BIT_HALF_TURN];
    wire [3:0] exp_field      = position_processing_config[`AVG_EXP_HI:`AVG_EXP_LO];
    wire [10:0] idle_wake_delta = idle_power_config[`WAKE_HI:0];
    wire [5:0] idle_period    = idle_power_config[`IDLE_PER_HI:`IDLE_PER_LO];

    // ==========================================================
    // Fault summary
    // Serial check faults only count while inbound checking is on
    wire crc_fault = spi_crc_bad_i & inbound_check_enable;
    wire word_t err_vec = {error_i[23], crc_fault, error_i[21:0]};
    wire word_t live_err = err_vec & ~fault_mask_word;
    wire next_fault   = |(live_err & `FAULT_BITS);
    wire next_caution = |(live_err & `CAUTION_BITS)
                        & ~fault_mask_word[`BIT_CAUTION_SUPPRESS];

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            fault_flag_o  <= 1'b0;
            caution_bit_o <= 1'b0;
        end else begin
            fault_flag_o  <= next_fault;
            caution_bit_o <= next_caution;
        end
    end

    // ==========================================================
    // Serial link options
    // Edge qualifier: the seventeenth edge is dropped when skipping
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            spi_edge_count_o <= 1'b0;
        end else begin
            spi_edge_count_o <= spi_edge17_i & ~skip_extra_edge;
        end
    end

    logic [2:0] supply_sync;
    logic       supply_state;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            supply_sync   <= 3'h0;
            supply_state  <= 1'b0;
            supply_link_o <= 1'b0;
        end else begin
            supply_sync <= {supply_sync[1:0], supply_link_i};
            if (supply_sync[1] == supply_sync[2]) begin
                supply_state <= supply_sync[2];
            end
            supply_link_o <= supply_state & ~ignore_supply_link;
        end
    end

    // ==========================================================
    // Averaging
    wire [3:0]  avg_exp   = (exp_field > `AVG_EXP_MAX) ? `AVG_EXP_MAX : exp_field;
    wire [12:0] avg_last  = 13'((14'h1 << avg_exp) - 14'h1);
    logic [12:0] avg_cnt;
    logic [23:0] avg_acc;
    logic        avg_valid;
    angle_t      avg_angle;
    wire [23:0] avg_sum   = avg_acc + {12'h000, angle_i};

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            avg_cnt   <= 13'h0000;
            avg_acc   <= 24'h000000;
            avg_valid <= 1'b0;
            avg_angle <= 12'h000;
        end else begin
            avg_valid <= 1'b0;
            if (angle_valid_i) begin
                if (avg_cnt >= avg_last) begin
                    avg_cnt   <= 13'h0000;
                    avg_acc   <= 24'h000000;
                    avg_valid <= 1'b1;
                    avg_angle <= 12'(avg_sum >> avg_exp);
                end else begin
                    avg_cnt <= avg_cnt + 13'h0001;
                    avg_acc <= avg_sum;
                end
            end
        end
    end

    // ==========================================================
    // Angle post-processing
    wire angle_t pre_ofs  = offset_after_lin ? avg_angle
                                             : avg_angle - zero_offset;
    wire angle_t lin_step = lin_span
                          ? angle_t'($signed(lin_corr_i) >>> `LIN_SHIFT_WIDE)
                          : angle_t'($signed(lin_corr_i) >>> `LIN_SHIFT_NARROW);
    wire angle_t lin_out  = lin_enable ? pre_ofs - lin_step : pre_ofs;
    wire angle_t dir_out  = turn_sense ? angle_t'(12'h000 - lin_out) : lin_out;
    wire angle_t post_ofs = offset_after_lin ? dir_out - zero_offset : dir_out;
    wire angle_t final_ang = half_turn_flip ? post_ofs + `HALF_TURN : post_ofs;

    // ==========================================================
    // Hysteresis filter on a 14-bit scale
    angle_t hyst_angle;
    wire [13:0] hyst_diff = {final_ang, 2'b00} - {hyst_angle, 2'b00};
    wire [13:0] hyst_mag  = hyst_diff[13] ? 14'(14'h0000 - hyst_diff) : hyst_diff;
    wire        hyst_move = hyst_mag > {8'h00, hyst_thr};

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            angle_out_o       <= 12'h000;
            angle_valid_o     <= 1'b0;
            hyst_angle        <= 12'h000;
            turns_angle_out_o <= 12'h000;
            pwm_angle_o       <= 12'h000;
        end else begin
            angle_valid_o <= avg_valid;
            if (avg_valid) begin
                angle_out_o <= final_ang;
                if (hyst_move) hyst_angle <= final_ang;
            end
            turns_angle_out_o <= turns_use_hyst ? hyst_angle : angle_out_o;
            pwm_angle_o       <= pwm_hyst_en ? hyst_angle : angle_out_o;
        end
    end

    // ==========================================================
    // PWM error response
    pwm_mode_t pwm_mode;
    pwm_mode_t next_pwm_mode;
    wire pwm_err_any = |pwm_err_i;
    logic [3:0] top_err;
    always_comb begin
        top_err = 4'h0;
        for (int i = 0; i < PWM_ERR_N; i++) begin
            if (pwm_err_i[i]) top_err = 4'(i + 1);
        end
    end

    always_comb begin
        next_pwm_mode = pwm_mode;
        case (pwm_mode)
            PWM_NORMAL: begin
                if (pwm_fault_out_en && pwm_err_any) begin
                    next_pwm_mode = pwm_fault_style ? PWM_HALF_RATE : PWM_RELEASED;
                end
            end
            PWM_RELEASED: begin
                // Latched: errors clearing alone do not bring the pin back
                if (!pwm_fault_out_en) next_pwm_mode = PWM_NORMAL;
            end
            PWM_HALF_RATE: begin
                if (!pwm_fault_out_en || !pwm_err_any) next_pwm_mode = PWM_NORMAL;
                else if (!pwm_fault_style) next_pwm_mode = PWM_RELEASED;
            end
            default: next_pwm_mode = PWM_NORMAL;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pwm_mode        <= PWM_NORMAL;
            pwm_pin_o       <= 1'b0;
            pwm_oe_o        <= 1'b0;
            pwm_half_rate_o <= 1'b0;
            pwm_err_code_o  <= 4'h0;
            pwm_rate_code_o <= 4'h0;
        end else begin
            pwm_mode        <= next_pwm_mode;
            pwm_pin_o       <= pwm_wave_i;
            pwm_oe_o        <= pwm_out_en && next_pwm_mode != PWM_RELEASED;
            pwm_half_rate_o <= next_pwm_mode == PWM_HALF_RATE;
            pwm_err_code_o  <= next_pwm_mode == PWM_HALF_RATE ? top_err : 4'h0;
            pwm_rate_code_o <= pwm_rate_code;
        end
    end

    // ==========================================================
    // Idle power wake comparison
    logic [$clog2(IDLE_STEP_CYCLES)-1:0] step_cnt;
    logic [5:0] period_cnt;
    angle_t     idle_ref;
    wire step_end   = step_cnt == ($bits(step_cnt))'(IDLE_STEP_CYCLES - 1);
    wire period_end = step_end && period_cnt >= idle_period;
    wire angle_t idle_diff = angle_out_o - idle_ref;
    wire [10:0] idle_mag = idle_diff[11] ? 11'(12'h000 - idle_diff) : idle_diff[10:0];
    wire big_move = idle_diff == `HALF_TURN || idle_mag >= idle_wake_delta;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            step_cnt       <= '0;
            period_cnt     <= 6'h00;
            idle_ref       <= 12'h000;
            force_normal_o <= 1'b0;
            idle_allowed_o <= 1'b0;
        end else begin
            step_cnt <= step_end ? '0 : step_cnt + 1'b1;
            if (step_end) period_cnt <= period_end ? 6'h00 : period_cnt + 6'h01;
            force_normal_o <= 1'b0;
            if (period_end) begin
                idle_ref       <= angle_out_o;
                force_normal_o <= low_power_i & big_move;
                idle_allowed_o <= ~low_power_i & ~big_move;
            end
        end
    end

    always_comb begin
        block_status = {16'h0000, 1'b0, pwm_oe_o, pwm_half_rate_o, idle_allowed_o,
                        supply_link_o, pwm_mode == PWM_RELEASED, caution_bit_o, fault_flag_o};
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    AST_MASKED_FAULT: assert property (
        error_i == 24'h001000 && !crc_fault && fault_mask_word[12] |=> !fault_flag_o)
        else $error("masked overflow error reached fault flag");
    AST_UNMASKED_FAULT: assert property (
        error_i[17] && !fault_mask_word[17] |=> fault_flag_o)
        else $error("unmasked soft error missing from fault flag");
    AST_CRC_IGNORED: assert property (
        error_i == 24'h0 && !inbound_check_enable |=> !fault_flag_o)
        else $error("frame check fault counted while checking is off");
    AST_CAUTION_SUPPRESS: assert property (
        fault_mask_word[`BIT_CAUTION_SUPPRESS] |=> !caution_bit_o)
        else $error("caution bit set while suppressed");
    AST_EDGE_SKIP: assert property (
        skip_extra_edge |=> !spi_edge_count_o)
        else $error("seventeenth edge passed while skipping");
    AST_SUPPLY_IGNORED: assert property (
        ignore_supply_link |=> !supply_link_o)
        else $error("supply link passed while disabled");
    AST_PWM_OFF: assert property (
        !pwm_out_en |=> !pwm_oe_o)
        else $error("pwm pin driven while disabled");
    AST_PWM_LATCH: assert property (
        pwm_mode == PWM_RELEASED && pwm_fault_out_en && !reg_wr_i
        |=> pwm_mode == PWM_RELEASED ##1 !pwm_oe_o)
        else $error("released pwm pin came back without clearing");
    AST_HALF_RATE: assert property (
        pwm_fault_out_en && pwm_fault_style && pwm_err_any && pwm_mode == PWM_NORMAL
        |=> pwm_half_rate_o && pwm_err_code_o != 4'h0)
        else $error("style one error did not halve pwm rate");
    AST_TURNS_SEL: assert property (
        !turns_use_hyst |=> turns_angle_out_o == $past(angle_out_o))
        else $error("turns angle not taken from raw angle");
    AST_HALF_TURN: assert property (
        avg_valid && half_turn_flip |=> angle_out_o == $past(post_ofs) + `HALF_TURN)
        else $error("half-turn flip not applied");

    COV_FAULT: cover property (fault_flag_o ##1 !fault_flag_o);
    COV_RELEASE: cover property (pwm_mode == PWM_RELEASED ##[1:20] pwm_mode == PWM_NORMAL);
    COV_WAKE: cover property (force_normal_o);

endmodule
`default_nettype wire

//--- bench/tb_angle_sensor_config_words.sv
// Purpose: self-checking bench for the angle sensor configuration words
// Assumes: reads return data one cycle after the strobe
// Notes:   idle step shortened to 16 cycles
`timescale 1ns/1ps
`default_nettype none
`include "angle_sensor_params.svh"

module tb_angle_sensor_config_words
    import angle_sensor_pkg::*;
;
    logic        ref_clk_i, rst_i, reg_wr_i, reg_rd_i, spi_crc_bad_i, spi_edge17_i;
    logic        supply_link_i, angle_valid_i, low_power_i, pwm_wave_i;
    logic [7:0]  reg_addr_i;
    logic [23:0] reg_wdata_i, error_i;
    logic [11:0] angle_i, lin_corr_i;
    logic [10:0] pwm_err_i;
    logic [23:0] reg_rdata_o;
    logic        fault_flag_o, caution_bit_o, angle_valid_o, pwm_oe_o;
    logic [11:0] angle_out_o;
    logic        spi_edge_count_o, supply_link_o, pwm_half_rate_o, pwm_pin_o;
    logic        force_normal_o, idle_allowed_o;
    logic [11:0] turns_angle_out_o, pwm_angle_o;
    logic [3:0]  pwm_err_code_o, pwm_rate_code_o;
    int          fails, checks_done;

    angle_sensor_config_words #(.IDLE_STEP_CYCLES(16)) dut_u (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .error_i(error_i), .spi_crc_bad_i(spi_crc_bad_i),
        .spi_edge17_i(spi_edge17_i), .supply_link_i(supply_link_i),
        .angle_valid_i(angle_valid_i), .angle_i(angle_i), .lin_corr_i(lin_corr_i),
        .low_power_i(low_power_i), .pwm_err_i(pwm_err_i), .pwm_wave_i(pwm_wave_i),
        .fault_flag_o(fault_flag_o), .caution_bit_o(caution_bit_o),
        .spi_edge_count_o(spi_edge_count_o), .supply_link_o(supply_link_o),
        .angle_out_o(angle_out_o), .angle_valid_o(angle_valid_o),
        .turns_angle_out_o(turns_angle_out_o), .pwm_angle_o(pwm_angle_o),
        .pwm_pin_o(pwm_pin_o), .pwm_oe_o(pwm_oe_o), .pwm_half_rate_o(pwm_half_rate_o),
        .pwm_err_code_o(pwm_err_code_o), .pwm_rate_code_o(pwm_rate_code_o),
        .force_normal_o(force_normal_o), .idle_allowed_o(idle_allowed_o)
    );

    // ==========================================================
    // Clock, shared tasks
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [23:0] d);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1; reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    // Waits two edges so a registered level has settled
    task automatic settle();
        repeat (2) @(posedge ref_clk_i);
        #1;
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_regs();
        logic [23:0] d;
        for (int i = 0; i < 4; i++) begin
            rd(`OFS_FAULT_MASK + 8'(i), d); chk(d, 24'h000000);
            wr(`OFS_FAULT_MASK + 8'(i), 24'hA5C3 + 24'(i));
            rd(`OFS_FAULT_MASK + 8'(i), d); chk(d, 24'hA5C3 + 24'(i));
            wr(`OFS_FAULT_MASK + 8'(i), 24'h000000);
        end
        rd(8'h05, d); chk(d, 24'h000000);
        $display("register test done");
    endtask

    task automatic test_faults();
        int bits [4] = '{10, 12, 17, 23};
        foreach (bits[k]) begin
            @(posedge ref_clk_i);
            error_i <= 24'h1 << bits[k];
            settle(); chk(fault_flag_o, 24'h1);
            wr(`OFS_FAULT_MASK, 24'h1 << bits[k]);
            settle(); chk(fault_flag_o, 24'h0);
            wr(`OFS_FAULT_MASK, 24'h000000);
        end
        @(posedge ref_clk_i);
        error_i <= 24'h010000;
        settle(); chk(caution_bit_o, 24'h1);
        wr(`OFS_FAULT_MASK, 24'h000800);
        settle(); chk(caution_bit_o, 24'h0);
        @(posedge ref_clk_i);
        error_i <= 24'h000000;
        wr(`OFS_FAULT_MASK, 24'h000000);
        $display("fault test done");
    endtask

    task automatic test_link();
        wr(`OFS_OUTPUT_CFG, 24'h000001);
        spi_crc_bad_i <= 1'b1;
        spi_edge17_i  <= 1'b1;
        supply_link_i <= 1'b1;
        // Three synchroniser stages, agreement and output register
        repeat (5) @(posedge ref_clk_i);
        #1 chk(supply_link_o, 24'h1);
        chk(spi_edge_count_o, 24'h1);
        chk(fault_flag_o, 24'h1);
        wr(`OFS_FAULT_MASK, 24'h400000);
        settle(); chk(fault_flag_o, 24'h0);
        wr(`OFS_FAULT_MASK, 24'h000000);
        wr(`OFS_OUTPUT_CFG, 24'h00000A);
        settle(); chk(fault_flag_o, 24'h0);
        chk(spi_edge_count_o, 24'h0);
        chk(supply_link_o, 24'h0);
        wr(`OFS_OUTPUT_CFG, 24'h000000);
        spi_crc_bad_i <= 1'b0;
        spi_edge17_i  <= 1'b0;
        supply_link_i <= 1'b0;
        $display("link test done");
    endtask

    task automatic test_pwm();
        wr(`OFS_OUTPUT_CFG, 24'h800000);
        settle(); chk(pwm_oe_o, 24'h1);
        wr(`OFS_OUTPUT_CFG, 24'h802000);
        pwm_err_i <= 11'h004;
        settle(); chk(pwm_oe_o, 24'h0);
        @(posedge ref_clk_i);
        pwm_err_i <= 11'h000;
        settle(); chk(pwm_oe_o, 24'h0);
        wr(`OFS_OUTPUT_CFG, 24'h800000);
        settle(); chk(pwm_oe_o, 24'h1);
        wr(`OFS_OUTPUT_CFG, 24'h8A3000);
        pwm_err_i  <= 11'h404;
        pwm_wave_i <= 1'b1;
        settle(); chk(pwm_half_rate_o, 24'h1);
        chk(pwm_err_code_o, 24'h00000B);
        chk(pwm_rate_code_o, 24'h00000A);
        chk(pwm_pin_o, 24'h1);
        chk(pwm_oe_o, 24'h1);
        @(posedge ref_clk_i);
        pwm_err_i  <= 11'h000;
        pwm_wave_i <= 1'b0;
        settle(); chk(pwm_half_rate_o, 24'h0);
        chk(pwm_err_code_o, 24'h000000);
        wr(`OFS_OUTPUT_CFG, 24'h000000);
        settle(); chk(pwm_oe_o, 24'h0);
        $display("pwm test done");
    endtask

    task automatic test_angle();
        logic [23:0] cfg [2] = '{24'h000010, 24'h080010};
        logic [11:0] exp [2] = '{12'h0F0, 12'h8F0};
        foreach (cfg[k]) begin
            wr(`OFS_POSITION_CFG, cfg[k]);
            angle_i <= 12'h100; angle_valid_i <= 1'b1;
            @(posedge ref_clk_i);
            angle_valid_i <= 1'b0;
            // Averager register, then output register
            @(posedge ref_clk_i);
            #1 chk(angle_valid_o, 24'h1);
            chk(angle_out_o, exp[k]);
            @(posedge ref_clk_i);
            #1 chk(turns_angle_out_o, exp[k]);
            chk(pwm_angle_o, exp[k]);
        end
        $display("angle test done");
    endtask

    task automatic test_idle();
        int hits = 0;
        @(posedge ref_clk_i);
        low_power_i <= 1'b1;
        // Zero wake delta: exactly one wake pulse per 16-cycle period
        repeat (16) begin
            @(posedge ref_clk_i);
            #1 hits += int'(force_normal_o);
        end
        chk(24'(hits), 24'h000001);
        @(posedge ref_clk_i);
        low_power_i <= 1'b0;
        wr(`OFS_IDLE_POWER_CFG, 24'h0007FF);
        repeat (17) @(posedge ref_clk_i);
        #1 chk(idle_allowed_o, 24'h1);
        $display("idle test done");
    endtask

    // ==========================================================
    // Sequence and verdict
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        fails = 0; checks_done = 0; rst_i = 1'b1; reg_wr_i = 1'b0; reg_rd_i = 1'b0;
        reg_addr_i = 8'h00; reg_wdata_i = 24'h000000; error_i = 24'h000000;
        spi_crc_bad_i = 1'b0; spi_edge17_i = 1'b0; supply_link_i = 1'b0;
        angle_valid_i = 1'b0; angle_i = 12'h000; lin_corr_i = 12'h000;
        low_power_i = 1'b0; pwm_err_i = 11'h000; pwm_wave_i = 1'b0;
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        test_regs(); test_faults(); test_link(); test_pwm(); test_angle(); test_idle();
        end_sim();
    end

    initial begin
        repeat (5000) @(posedge ref_clk_i);
        fails++;
        end_sim();
    end
endmodule
`default_nettype wire
